// [rsp_cfg.svh]
/*
 Constants of the serial configuration and status port: address map,
 status byte layout and state codes.
 Assumes it is included by bare name from the package and modules.
*/
`ifndef RSP_CFG_SVH
`define RSP_CFG_SVH

// Address map of the six-bit header address
`define RSP_CFG_LAST 6'h2E
`define RSP_STAT_FIRST 6'h30
`define RSP_STAT_LAST 6'h3D
`define RSP_STROBE_BASE 3'h6
`define RSP_RXF_ADDR 6'h3F

// Header bit positions
`define RSP_HDR_RW 7
`define RSP_HDR_BURST 6

// Status byte: state field codes and count saturation
`define RSP_ST_IDLE 3'h0
`define RSP_ST_RX 3'h1
`define RSP_ST_CAL 3'h4
`define RSP_ST_SETTLE 3'h5
`define RSP_ST_OVF 3'h6
`define RSP_CNT_SAT 4'hF

// Bit slots of one byte and write-buffer depth
`define RSP_LAST_BIT 3'h7
`define RSP_WR_DEPTH 8

`endif

// [rsp_pkg.sv]
/*
 Types of the serial configuration and status port.
 Assumes rsp_cfg.svh is on the include path.
*/
`include "rsp_cfg.svh"

package rsp_pkg;
   typedef enum logic [2:0] {PH_HEADER, PH_WRITE, PH_READ, PH_RXF,
      PH_IGNORE} rsp_phase_e;
   // Order follows strobe address 0x30 upward
   typedef enum logic [2:0] {STB_SOFT_RESET, STB_CRYSTAL_OFF,
      STB_CALIBRATE, STB_ENTER_RX, STB_GO_IDLE, STB_POWER_DOWN,
      STB_RX_FLUSH, STB_NOP} rsp_strobe_e;
   typedef enum logic [2:0] {RAD_IDLE, RAD_RX, RAD_CAL, RAD_SETTLE,
      RAD_OVERFLOW, RAD_OTHER} rsp_radio_e;
endpackage : rsp_pkg

// [rsp_fifo_if.sv]
/*
 Valid/ready carrier between the port and its write buffer.
 Assumes both sides run on one clock.
*/
`timescale 1ns/1ps
`default_nettype none

interface rsp_fifo_if #(parameter int W = 14);
   logic push_valid;
   logic push_ready;
   logic [W-1:0] push_data;
   logic pop_valid;
   logic pop_ready;
   logic [W-1:0] pop_data;
   modport fifo (input push_valid, push_data, pop_ready,
      output push_ready, pop_valid, pop_data);
   modport user (output push_valid, push_data, pop_ready,
      input push_ready, pop_valid, pop_data);
endinterface : rsp_fifo_if

`default_nettype wire

// [rsp_fifo.sv]
/*
 Small synchronous FIFO with valid/ready on both sides.
 Assumes one clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none

module rsp_fifo #(parameter int W = 14, parameter int DEPTH = 8)
(
   input wire logic i_clock,
   input wire logic i_rst_n,
   rsp_fifo_if.fifo f
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] fill;
   logic do_push;
   logic do_pop;

   assign f.push_ready = (fill != (AW+1)'(DEPTH));
   assign f.pop_valid = (fill != '0);
   assign f.pop_data = mem[rd_ptr];
   assign do_push = f.push_valid && f.push_ready;
   assign do_pop = f.pop_valid && f.pop_ready;

   always_ff @(posedge i_clock)
   begin
      if (do_push)
         mem[wr_ptr] <= f.push_data;
   end

   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         fill <= '0;
      end
      else
      begin
         if (do_push)
            wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
         if (do_pop)
            rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
         fill <= fill + (AW+1)'(do_push) - (AW+1)'(do_pop);
      end
   end
endmodule : rsp_fifo

`default_nettype wire

// [rsp_spi_port.sv]
/*
 Serial slave port: header decode, status byte, single and burst
 register access, status reads, receive-buffer reads and strobes.
 Assumes the serial pins come from another domain, and that register
 read data follow o_cfg_addr within one clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rsp_cfg.svh"

module rsp_spi_port import rsp_pkg::*;
#(
   parameter int CNT_W = 7,
   parameter int WR_DEPTH = `RSP_WR_DEPTH
)
(
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic i_select_low,
   input wire logic i_sclk,
   input wire logic i_si,
   output logic o_so,
   output logic o_so_oe,
   input wire logic i_xtal_ready,
   input wire rsp_radio_e i_radio_state,
   input wire logic [CNT_W-1:0] i_rx_count,
   output logic [5:0] o_cfg_addr,
   input wire logic [7:0] i_cfg_rdata,
   output logic o_wr_valid,
   output logic [5:0] o_wr_addr,
   output logic [7:0] o_wr_data,
   input wire logic i_wr_ready,
   output logic o_wr_drop,
   input wire logic [7:0] i_rxf_data,
   output logic o_rxf_pop,
   output logic o_strobe,
   output rsp_strobe_e o_strobe_code
);
   logic [2:0] meta;
   logic [2:0] pins;
   logic [2:0] pins_d;
   logic active;
   logic sclk;
   logic rise;
   logic fall;
   logic cs_rise;
   logic [2:0] bit_cnt;
   logic [7:0] rx;
   logic [7:0] tx;
   logic load_next;
   logic byte_done;
   logic [7:0] byte_val;
   rsp_phase_e phase;
   rsp_phase_e next_phase;
   logic [5:0] addr;
   logic [5:0] next_addr;
   logic burst;
   logic next_burst;
   logic strobe_hit;
   rsp_strobe_e strobe_code;
   logic pend_pd;
   logic pend_xo;
   logic idle_block;
   logic [7:0] status;
   logic drop;

   function automatic logic is_status_addr(input logic [5:0] a);
      return (a >= `RSP_STAT_FIRST) && (a <= `RSP_STAT_LAST);
   endfunction : is_status_addr

   function automatic logic [7:0] status_fn(input logic rdy,
      input rsp_radio_e st, input logic [CNT_W-1:0] cnt);
      logic [2:0] code;
      code = `RSP_ST_IDLE;
      case (st)
         RAD_RX: code = `RSP_ST_RX;
         RAD_CAL: code = `RSP_ST_CAL;
         RAD_SETTLE: code = `RSP_ST_SETTLE;
         RAD_OVERFLOW: code = `RSP_ST_OVF;
         default: code = `RSP_ST_IDLE;
      endcase
      return {!rdy, code, (cnt >= CNT_W'(`RSP_CNT_SAT)) ?
         `RSP_CNT_SAT : cnt[3:0]};
   endfunction : status_fn

   // Pins pass two flip-flops; pins_d only serves edge detection
   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         meta <= 3'h4;
         pins <= 3'h4;
         pins_d <= 3'h4;
      end
      else
      begin
         meta <= {i_select_low, i_sclk, i_si};
         pins <= meta;
         pins_d <= pins;
      end
   end

   assign active = !pins[2];
   assign sclk = pins[1];
   assign rise = active && sclk && !pins_d[1];
   assign fall = active && !sclk && pins_d[1];
   assign cs_rise = pins[2] && !pins_d[2];
   assign byte_val = {rx[6:0], pins[0]};
   assign byte_done = rise && (bit_cnt == `RSP_LAST_BIT);
   assign status = status_fn(i_xtal_ready, i_radio_state, i_rx_count);

   always_comb
   begin
      next_phase = phase;
      next_addr = addr;
      next_burst = burst;
      strobe_hit = 1'b0;
      strobe_code = rsp_strobe_e'(byte_val[2:0]);
      if (byte_done)
      begin
         case (phase)
            PH_HEADER:
            begin
               next_addr = byte_val[5:0];
               next_burst = byte_val[`RSP_HDR_BURST];
               if (byte_val[5:0] <= `RSP_CFG_LAST)
                  next_phase = byte_val[`RSP_HDR_RW] ? PH_READ : PH_WRITE;
               else if (is_status_addr(byte_val[5:0]))
               begin
                  if (byte_val[`RSP_HDR_BURST])
                  begin
                     next_burst = 1'b0;
                     next_phase = byte_val[`RSP_HDR_RW] ? PH_READ :
                        PH_IGNORE;
                  end
                  else
                     strobe_hit = (byte_val[5:3] == `RSP_STROBE_BASE);
               end
               else if (byte_val[5:0] == `RSP_RXF_ADDR &&
                  byte_val[`RSP_HDR_RW])
                  next_phase = PH_RXF;
               else
                  next_phase = PH_IGNORE;
            end
            default:
            begin
               if (burst)
                  next_addr = addr + 6'h01;
               else
                  next_phase = PH_HEADER;
            end
         endcase
      end
   end

   // Select high ends any access, keeping only whole bytes already taken
   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         phase <= PH_HEADER;
         addr <= 6'h00;
         burst <= 1'b0;
      end
      else if (!active)
      begin
         phase <= PH_HEADER;
         burst <= 1'b0;
      end
      else
      begin
         phase <= next_phase;
         addr <= next_addr;
         burst <= next_burst;
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         bit_cnt <= 3'h0;
         rx <= 8'h00;
         tx <= 8'hFF;
         load_next <= 1'b0;
      end
      else if (!active)
      begin
         bit_cnt <= 3'h0;
         rx <= 8'h00;
         load_next <= 1'b0;
         tx <= status;
      end
      else if (fall)
      begin
         load_next <= 1'b0;
         if (!load_next)
            tx <= {tx[6:0], 1'b0};
         else if (phase == PH_READ)
            // One capture per byte; a status word moving then may read torn
            tx <= i_cfg_rdata;
         else if (phase == PH_RXF)
            tx <= i_rxf_data;
         else
            tx <= status;
      end
      else if (rise)
      begin
         rx <= byte_val;
         bit_cnt <= bit_cnt + 3'h1;
         if (byte_done)
            load_next <= 1'b1;
         // Count means nothing to a write header, so it reads as zero
         if (phase == PH_HEADER && bit_cnt == 3'h0 && !pins[0])
            tx[3:0] <= 4'h0;
      end
      else if (phase == PH_HEADER && bit_cnt == 3'h0 && !load_next &&
         !sclk)
         tx <= status;
   end

   assign o_so = tx[7];
   assign o_so_oe = active;
   assign o_cfg_addr = addr;

   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
         o_rxf_pop <= 1'b0;
      else
         // Taken only once fully shifted out, so a cut burst loses nothing
         o_rxf_pop <= byte_done && phase == PH_RXF;
   end

   // Strobe sequencing; a new go-idle wins over the idle release
   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         pend_pd <= 1'b0;
         pend_xo <= 1'b0;
         idle_block <= 1'b0;
         o_strobe <= 1'b0;
         o_strobe_code <= STB_NOP;
      end
      else
      begin
         o_strobe <= 1'b0;
         if (i_radio_state == RAD_IDLE)
            idle_block <= 1'b0;
         if (strobe_hit && !idle_block)
         begin
            case (strobe_code)
               STB_POWER_DOWN: pend_pd <= 1'b1;
               STB_CRYSTAL_OFF: pend_xo <= 1'b1;
               default:
               begin
                  o_strobe <= 1'b1;
                  o_strobe_code <= strobe_code;
                  if (strobe_code == STB_GO_IDLE)
                  begin
                     pend_pd <= 1'b0;
                     pend_xo <= 1'b0;
                     idle_block <= 1'b1;
                  end
               end
            endcase
         end
         else if (cs_rise && pend_pd)
         begin
            o_strobe <= 1'b1;
            o_strobe_code <= STB_POWER_DOWN;
            pend_pd <= 1'b0;
         end
         else if (!active && !pend_pd && pend_xo)
         begin
            o_strobe <= 1'b1;
            o_strobe_code <= STB_CRYSTAL_OFF;
            pend_xo <= 1'b0;
         end
      end
   end

   // A write arriving to a full buffer is lost and reported
   rsp_fifo_if #(.W(14)) wq ();
   assign wq.push_valid = byte_done && phase == PH_WRITE;
   assign wq.push_data = {addr, byte_val};
   assign wq.pop_ready = i_wr_ready;
   assign o_wr_valid = wq.pop_valid;
   assign o_wr_addr = wq.pop_data[13:8];
   assign o_wr_data = wq.pop_data[7:0];
   assign drop = wq.push_valid && !wq.push_ready;

   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
         o_wr_drop <= 1'b0;
      else
         o_wr_drop <= drop;
   end

   rsp_fifo #(.W(14), .DEPTH(WR_DEPTH)) u_wq
   (
      .i_clock(i_clock),
      .i_rst_n(i_rst_n),
      .f(wq)
   );

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rst_n);

   property p_ready_bit;
      active && phase == PH_HEADER && bit_cnt == 3'h0 && !load_next &&
         !sclk && !fall && !rise ##1 !rise && !fall
         |-> o_so == !$past(i_xtal_ready);
   endproperty
   a_ready_bit: assert property (p_ready_bit)
      else $error("ready flag not shown on SO");

   property p_no_reserved;
      !(status[6:4] inside {3'h2, 3'h3, 3'h7});
   endproperty
   a_no_reserved: assert property (p_no_reserved)
      else $error("reserved state code reported");

   property p_count_sat;
      status[3:0] == ((i_rx_count > CNT_W'(14)) ? 4'hF : i_rx_count[3:0]);
   endproperty
   a_count_sat: assert property (p_count_sat)
      else $error("buffer count field wrong");

   property p_pd_deferred;
      o_strobe && o_strobe_code inside {STB_POWER_DOWN, STB_CRYSTAL_OFF}
         |-> $past(!active);
   endproperty
   a_pd_deferred: assert property (p_pd_deferred)
      else $error("deferred strobe issued while selected");

   property p_idle_ignore;
      idle_block && strobe_hit |=> !o_strobe;
   endproperty
   a_idle_ignore: assert property (p_idle_ignore)
      else $error("strobe accepted before idle reached");

   property p_write_push;
      byte_done && phase == PH_WRITE && wq.push_ready
         |=> o_wr_valid;
   endproperty
   a_write_push: assert property (p_write_push)
      else $error("write byte not pushed");

   property p_burst_step;
      byte_done && burst && phase != PH_HEADER |=>
         addr == $past(addr) + 6'h01 && phase == $past(phase);
   endproperty
   a_burst_step: assert property (p_burst_step)
      else $error("burst address did not advance");

   property p_abandon;
      cs_rise |=> phase == PH_HEADER && bit_cnt == 3'h0 && !load_next;
   endproperty
   a_abandon: assert property (p_abandon)
      else $error("transfer not abandoned on select high");

   property p_strobe_header;
      byte_done && phase == PH_HEADER && !byte_val[6] &&
         is_status_addr(byte_val[5:0]) |=> phase == PH_HEADER;
   endproperty
   a_strobe_header: assert property (p_strobe_header)
      else $error("strobe did not return to header");

   property p_rxf_pop;
      phase == PH_RXF && byte_done |=> o_rxf_pop ##1 !o_rxf_pop;
   endproperty
   a_rxf_pop: assert property (p_rxf_pop)
      else $error("buffer byte not popped");

   c_burst_write: cover property (byte_done && burst && phase == PH_WRITE);
   c_strobe: cover property (o_strobe && o_strobe_code == STB_ENTER_RX);
   c_rxf_burst: cover property (o_rxf_pop && burst);
   c_deferred: cover property (o_strobe &&
      o_strobe_code == STB_POWER_DOWN);
endmodule : rsp_spi_port

`default_nettype wire

// [rsp_host_model.sv]
/*
 Host model: the serial master that talks to the configuration port.
 Assumes it shares the system clock and moves its pins after rising edges.
*/
`timescale 1ns/1ps
`default_nettype none

module rsp_host_model
(
   input wire logic i_clock,
   input wire logic i_so,
   input wire logic i_so_oe,
   output logic o_select_low,
   output logic o_sclk,
   output logic o_si
);
   logic last_so = 1'b0;
   logic so_seen;
   int wait_fail = 0;

   initial
   begin
      o_select_low = 1'b1;
      o_sclk = 1'b0;
      o_si = 1'b0;
   end

   // A released line reads back as the inverse of its last driven level
   always @(posedge i_clock)
   begin
      if (i_so_oe)
         last_so <= i_so;
   end
   assign so_seen = i_so_oe ? i_so : ~last_so;

   // No clock rise until the ready flag is low or 200 clocks have passed
   task automatic wait_ready();
      int n;
      n = 0;
      repeat (3) @(posedge i_clock);
      while (!(i_so_oe && so_seen == 1'b0) && n < 200)
      begin
         @(posedge i_clock);
         n++;
      end
      if (n == 200)
         wait_fail++;
   endtask : wait_ready

   task automatic open_frame();
      @(posedge i_clock);
      o_select_low <= 1'b0;
      wait_ready();
   endtask : open_frame

   // Clock idles low; SI moves while low, SO taken at the rise
   task automatic xfer(input logic [7:0] tx, input int nbits,
      output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 7; i > 7 - nbits; i--)
      begin
         o_si <= tx[i];
         repeat (4) @(posedge i_clock);
         o_sclk <= 1'b1;
         rx[i] = so_seen;
         repeat (4) @(posedge i_clock);
         o_sclk <= 1'b0;
      end
   endtask : xfer

   task automatic close_frame();
      repeat (2) @(posedge i_clock);
      o_select_low <= 1'b1;
      repeat (8) @(posedge i_clock);
   endtask : close_frame
endmodule : rsp_host_model

`default_nettype wire

// [testbench.sv]
/*
 Self-checking bench of the serial port with the host model in front.
 Assumes the design files and the host model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module testbench import rsp_pkg::*;
;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic select_low, sclk, si, so, so_oe;
   logic xtal_ready = 1'b0;
   rsp_radio_e radio_state = RAD_IDLE;
   logic [6:0] rx_count = 7'h00;
   logic [5:0] cfg_addr, wr_addr;
   logic [7:0] cfg_rdata = 8'h00;
   logic [7:0] wr_data, rx;
   logic [7:0] rxf_data = 8'h00;
   logic wr_valid, wr_drop, rxf_pop, strobe;
   logic wr_ready = 1'b0;
   logic drop_seen = 1'b0;
   rsp_strobe_e strobe_code;
   int bad_count = 0;
   int n_checks = 0;
   int cycles = 0;
   int n_strobes = 0;
   int n_pops = 0;

   always #20 clock = ~clock;

   rsp_host_model host (.i_clock(clock), .i_so(so), .i_so_oe(so_oe),
      .o_select_low(select_low), .o_sclk(sclk), .o_si(si));

   rsp_spi_port DUT (.i_clock(clock), .i_rst_n(rst_n),
      .i_select_low(select_low), .i_sclk(sclk), .i_si(si), .o_so(so),
      .o_so_oe(so_oe), .i_xtal_ready(xtal_ready),
      .i_radio_state(radio_state), .i_rx_count(rx_count),
      .o_cfg_addr(cfg_addr), .i_cfg_rdata(cfg_rdata),
      .o_wr_valid(wr_valid), .o_wr_addr(wr_addr), .o_wr_data(wr_data),
      .i_wr_ready(wr_ready), .o_wr_drop(wr_drop), .i_rxf_data(rxf_data),
      .o_rxf_pop(rxf_pop), .o_strobe(strobe), .o_strobe_code(strobe_code));

   function automatic logic [7:0] cfg_value(input logic [5:0] a);
      return {2'h2, a} ^ 8'h3C;
   endfunction : cfg_value

   function automatic logic [7:0] stat(input logic rw);
      logic [2:0] code;
      logic [3:0] cnt;
      case (radio_state)
         RAD_RX: code = 3'h1;
         RAD_CAL: code = 3'h4;
         RAD_SETTLE: code = 3'h5;
         RAD_OVERFLOW: code = 3'h6;
         default: code = 3'h0;
      endcase
      cnt = (rx_count > 7'h0F) ? 4'hF : rx_count[3:0];
      return {~xtal_ready, code, rw ? cnt : 4'h0};
   endfunction : stat

   // Register file answers one clock after the address moves
   always @(posedge clock)
   begin
      cfg_rdata <= cfg_value(cfg_addr);
      cycles <= cycles + 1;
      if (strobe)
         n_strobes <= n_strobes + 1;
      if (rxf_pop)
         n_pops <= n_pops + 1;
      if (wr_drop)
         drop_seen <= 1'b1;
      if (cycles == 30000)
      begin
         bad_count++;
         conclude();
      end
   end

   task automatic check(input string what, input logic [7:0] exp,
      input logic [7:0] got);
      n_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic conclude();
      if (bad_count == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : conclude

   task automatic t_ready();
      fork
         host.open_frame();
         begin
            repeat (20) @(posedge clock);
            check("ready flag", 8'h01, {7'h00, so});
            xtal_ready <= 1'b1;
         end
      join
      check("ready wait", 8'h00, 8'(host.wait_fail));
      host.xfer(8'hB7, 8, rx);
      check("status", stat(1'b1), rx);
      host.close_frame();
   endtask : t_ready

   task automatic t_states();
      for (int i = 0; i < 6; i++)
      begin
         radio_state <= rsp_radio_e'(i);
         rx_count <= 7'(i * 4);
         host.open_frame();
         host.xfer(8'hB7, 8, rx);
         check("status rd", stat(1'b1), rx);
         host.xfer(8'h37, 8, rx);
         check("status wr", stat(1'b0), rx);
         host.close_frame();
      end
      radio_state <= RAD_IDLE;
   endtask : t_states

   task automatic t_write();
      host.open_frame();
      host.xfer(8'h05, 8, rx);
      check("wr hdr", stat(1'b0), rx);
      host.xfer(8'hA5, 8, rx);
      // Data bytes carry the full status; only a write header clears count
      check("wr data", stat(1'b1), rx);
      host.xfer(8'h40, 8, rx);
      for (int k = 0; k < 8; k++)
      begin
         host.xfer(8'(8'h10 + k), 8, rx);
         check("burst st", stat(1'b1), rx);
      end
      host.close_frame();
      check("drop", 8'h01, {7'h00, drop_seen});
      for (int k = 0; k < 8; k++)
      begin
         check("wr addr", {2'h0, k == 0 ? 6'h05 : 6'(k - 1)},
            {2'h0, wr_addr});
         check("wr val", k == 0 ? 8'hA5 : 8'(8'h0F + k), wr_data);
         wr_ready <= 1'b1;
         @(posedge clock);
         wr_ready <= 1'b0;
         @(posedge clock);
      end
      check("drained", 8'h00, {7'h00, wr_valid});
      host.open_frame();
      host.xfer(8'h06, 8, rx);
      host.xfer(8'h77, 4, rx);
      host.close_frame();
      check("abort", 8'h00, {7'h00, wr_valid});
   endtask : t_write

   task automatic t_read();
      int n0;
      rx_count <= 7'h14;
      rxf_data <= 8'h6D;
      host.open_frame();
      host.xfer(8'h85, 8, rx);
      check("rd hdr", stat(1'b1), rx);
      host.xfer(8'h00, 8, rx);
      check("rd data", cfg_value(6'h05), rx);
      host.xfer(8'hC2, 8, rx);
      check("burst hdr", stat(1'b1), rx);
      for (int k = 2; k < 4; k++)
      begin
         host.xfer(8'h00, 8, rx);
         check("burst rd", cfg_value(6'(k)), rx);
      end
      host.close_frame();
      n0 = n_pops;
      host.open_frame();
      host.xfer(8'hBF, 8, rx);
      check("rxf hdr", stat(1'b1), rx);
      host.xfer(8'h00, 8, rx);
      check("rxf data", 8'h6D, rx);
      // Pop pulses just after the byte's last bit; let its count land
      @(posedge clock);
      check("rxf pop", 8'h01, 8'(n_pops - n0));
      host.xfer(8'hF5, 8, rx);
      n0 = n_strobes;
      host.xfer(8'h00, 8, rx);
      check("stat rd", cfg_value(6'h35), rx);
      host.close_frame();
      check("stat reg", 8'h00, 8'(n_strobes - n0));
      n0 = n_pops;
      host.open_frame();
      host.xfer(8'hFF, 8, rx);
      for (int k = 0; k < 2; k++)
      begin
         host.xfer(8'h00, 8, rx);
         check("rxf burst", 8'h6D, rx);
      end
      host.close_frame();
      check("rxf pops", 8'h02, 8'(n_pops - n0));
   endtask : t_read

   task automatic t_strobes();
      int n0;
      for (int a = 0; a < 8; a++)
      begin
         n0 = n_strobes;
         host.open_frame();
         host.xfer(8'(8'h30 + a), 8, rx);
         repeat (6) @(posedge clock);
         check("early", (a == 1 || a == 5) ? 8'h00 : 8'h01,
            8'(n_strobes - n0));
         host.close_frame();
         check("strobes", 8'h01, 8'(n_strobes - n0));
         check("code", 8'(a), {5'h00, strobe_code});
      end
   endtask : t_strobes

   task automatic t_idle();
      int n0;
      radio_state <= RAD_RX;
      n0 = n_strobes;
      host.open_frame();
      host.xfer(8'h30, 8, rx);
      host.wait_ready();
      host.xfer(8'h35, 8, rx);
      host.xfer(8'h34, 8, rx);
      host.xfer(8'h33, 8, rx);
      host.close_frame();
      check("idle blk", 8'h02, 8'(n_strobes - n0));
      check("idle code", 8'(STB_GO_IDLE), {5'h00, strobe_code});
      radio_state <= RAD_IDLE;
      n0 = n_strobes;
      host.open_frame();
      host.xfer(8'h33, 8, rx);
      host.close_frame();
      check("unblock", 8'h01, 8'(n_strobes - n0));
      check("rx code", 8'(STB_ENTER_RX), {5'h00, strobe_code});
   endtask : t_idle

   initial
   begin
      repeat (6) @(posedge clock);
      rst_n <= 1'b1;
      repeat (4) @(posedge clock);
      t_ready();
      t_states();
      t_write();
      t_read();
      t_strobes();
      t_idle();
      conclude();
   end
endmodule : testbench

`default_nettype wire
